// file: dv/dac_link_properties.sv
// watches the host-driven link and the device outputs beside it
module dac_link_properties
    import dac_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic [CODE_W-1:0] dac_code_r,
    input wire logic [1:0] mode_r,
    input wire logic [THERMO_W-1:0] thermo_sw_r,
    input wire logic [LADDER_W-1:0] ladder_sw_r,
    input wire logic amp_connect_r,
    input wire logic core_on_r,
    input wire logic out_hiz_r,
    input wire logic pull_100k_r,
    input wire logic pull_1k_r,
    input wire logic update_pulse_r,
    input wire logic swreset_pulse_r
);
    logic [THERMO_W-1:0] thermo_exp; // expected switch pattern

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // thermometer of the top nibble
    always_comb begin
        for (int k = 0; k < THERMO_W; k++) begin
            thermo_exp[k] = int'(dac_code_r[15:12]) > k;
        end
    end

    property p_fall_in_frame;
        $fell(sclk) |-> !sync_n;
    endproperty
    a_fall_in_frame: assert property (p_fall_in_frame)
        else $error("serial clock fell with sync high");
    property p_sync_gap;
        $rose(sync_n) |=> sync_n;
    endproperty
    a_sync_gap: assert property (p_sync_gap)
        else $error("sync high gap shorter than two cycles");
    property p_din_steady;
        $fell(sclk) |-> $stable(din);
    endproperty
    a_din_steady: assert property (p_din_steady)
        else $error("data moved at the sampling edge");
    property p_amp_core;
        $stable(mode_r) |-> amp_connect_r == (mode_r == MODE_NORMAL)
            && core_on_r == (mode_r == MODE_NORMAL);
    endproperty
    a_amp_core: assert property (p_amp_core)
        else $error("amplifier or core state disagrees with mode");
    property p_pd_loads;
        $stable(mode_r) |-> {out_hiz_r, pull_100k_r, pull_1k_r} ==
            {mode_r == MODE_HIZ, mode_r == MODE_PD_100K,
            mode_r == MODE_PD_1K};
    endproperty
    a_pd_loads: assert property (p_pd_loads)
        else $error("power-down load disagrees with mode");
    property p_switches;
        $stable(dac_code_r) |-> thermo_sw_r == thermo_exp
            && ladder_sw_r == dac_code_r[11:0];
    endproperty
    a_switches: assert property (p_switches)
        else $error("switch pattern disagrees with code");
    property p_code_cause;
        $changed(dac_code_r) |-> update_pulse_r || swreset_pulse_r
            || $past(update_pulse_r) || $past(swreset_pulse_r);
    endproperty
    a_code_cause: assert property (p_code_cause)
        else $error("code changed without a complete frame");
    property p_swreset;
        swreset_pulse_r |-> ##[0:1] dac_code_r == MIDSCALE
            && mode_r == MODE_NORMAL;
    endproperty
    a_swreset: assert property (p_swreset)
        else $error("software reset did not restore midscale");
endmodule

// file: dv/test_dac_serial_write_port.sv
module test_dac_serial_write_port
    import dac_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, lclk, cmd_valid;
    logic [FRAME_BITS-1:0] cmd_word;
    logic cmd_ready_r, frame_sent_r, out_settled_r; // host status
    logic [CODE_W-1:0] dac_code_r, code2; // code of each device
    logic [1:0] mode_r, mode2;
    logic [THERMO_W-1:0] thermo_sw_r;
    logic [LADDER_W-1:0] ladder_sw_r;
    logic amp_connect_r, core_on_r, out_hiz_r, pull_100k_r, pull_1k_r;
    logic update_pulse_r, swreset_pulse_r;
    int failures = 0;
    int tests_run = 0;
    int upd_cnt = 0; // update pulses seen from the first device
    int swr_cnt = 0; // software reset pulses seen
    // one word per mode, plus ignored upper bits set
    logic [23:0] words [6] = '{24'h001234, 24'h01ffff, 24'h02ffff,
        24'h03ffff, 24'hfc5a5a, 24'h000000};
    dac_link_if link(); // host to device
    dac_link_if link2(); // bench to second device, for broken frames

    dac_write_host #(.RECOVER_CYC(200)) i_dac_write_host(.clk(clk),
        .rst(rst), .link(link), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .cmd_ready_r(cmd_ready_r),
        .frame_sent_r(frame_sent_r), .out_settled_r(out_settled_r));
    dac_serial_write_port i_dac_serial_write_port(.clk(clk), .rst(rst),
        .link(link), .dac_code_r(dac_code_r), .mode_r(mode_r),
        .thermo_sw_r(thermo_sw_r), .ladder_sw_r(ladder_sw_r),
        .amp_connect_r(amp_connect_r), .core_on_r(core_on_r),
        .out_hiz_r(out_hiz_r), .pull_100k_r(pull_100k_r),
        .pull_1k_r(pull_1k_r), .update_pulse_r(update_pulse_r),
        .swreset_pulse_r(swreset_pulse_r));
    dac_serial_write_port i_dac_serial_write_port2(.clk(clk), .rst(rst),
        .link(link2), .dac_code_r(code2), .mode_r(mode2),
        .thermo_sw_r(), .ladder_sw_r(), .amp_connect_r(), .core_on_r(),
        .out_hiz_r(), .pull_100k_r(), .pull_1k_r(), .update_pulse_r(),
        .swreset_pulse_r());
    dac_link_properties i_dac_link_properties(.clk(clk), .rst(rst),
        .sync_n(link.sync_n), .sclk(link.sclk), .din(link.din),
        .dac_code_r(dac_code_r), .mode_r(mode_r),
        .thermo_sw_r(thermo_sw_r), .ladder_sw_r(ladder_sw_r),
        .amp_connect_r(amp_connect_r), .core_on_r(core_on_r),
        .out_hiz_r(out_hiz_r), .pull_100k_r(pull_100k_r),
        .pull_1k_r(pull_1k_r), .update_pulse_r(update_pulse_r),
        .swreset_pulse_r(swreset_pulse_r));

    // system clock, and a link clock of unrelated phase
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3.3;
        forever #7.5 lclk = ~lclk;
    end

    // count event pulses; registered outputs, read before they update
    always @(posedge clk) begin
        if (update_pulse_r === 1'b1) begin
            upd_cnt++;
        end
        if (swreset_pulse_r === 1'b1) begin
            swr_cnt++;
        end
    end

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bit k set while the nibble exceeds k
    function automatic logic [14:0] thermo_of(input logic [3:0] n);
        logic [14:0] r;
        for (int k = 0; k < 15; k++) begin
            r[k] = int'(n) > k;
        end
        return r;
    endfunction

    // one request to the host end, then let the device settle
    task send(input logic [FRAME_BITS-1:0] w);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // bounded wait; sampled mid-cycle to avoid edge races
        do begin
            @(negedge clk);
            n++;
        end while (frame_sent_r !== 1'b1 && n < 300);
        repeat (8) @(negedge clk);
    endtask

    // device outputs against one frame
    task expect_frame(input logic [23:0] w);
        check(dac_code_r, w[15:0]);
        check(mode_r, w[17:16]);
        check(thermo_sw_r, thermo_of(w[15:12]));
        check(ladder_sw_r, w[11:0]);
        check(amp_connect_r, w[17:16] == MODE_NORMAL);
        check(core_on_r, w[17:16] == MODE_NORMAL);
        check(out_hiz_r, w[17:16] == MODE_HIZ);
        check(pull_100k_r, w[17:16] == MODE_PD_100K);
        check(pull_1k_r, w[17:16] == MODE_PD_1K);
    endtask

    // bench-driven sync; a released data line shows the inverse
    task sync2(input logic v);
        @(posedge lclk);
        link2.sync_n <= v;
        if (v) begin
            link2.din <= ~link2.din;
        end
    endtask

    // bits hi..lo msb first, taken on the falling clock
    task bits2(input logic [23:0] w, input int hi, input int lo);
        for (int i = hi; i >= lo; i--) begin
            @(posedge lclk);
            link2.din <= w[i];
            link2.sclk <= 1'b1;
            @(negedge lclk);
            link2.sclk <= 1'b0;
        end
        @(posedge lclk);
        link2.sclk <= 1'b1;
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        #100000;
        failures++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_word = '0;
        link2.sync_n = 1'b1;
        link2.sclk = 1'b1;
        link2.din = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(dac_code_r, MIDSCALE);
        check(thermo_sw_r, 15'h00ff);
        check(core_on_r, 1'b1);
        // every mode, boundary codes, ignored top bits
        for (int i = 0; i < 6; i++) begin
            send(words[i]);
            expect_frame(words[i]);
            if (i == 4) begin
                check(out_settled_r, 1'b0);
            end
        end
        repeat (300) @(negedge clk);
        check(out_settled_r, 1'b1);
        send(24'h031234);
        send(SWRESET_WORD);
        check(dac_code_r, MIDSCALE);
        check(mode_r, MODE_NORMAL);
        check(out_settled_r, 1'b0);
        // early sync rise after ten bits
        sync2(1'b0);
        bits2(24'h00abcd, 23, 14);
        sync2(1'b1);
        repeat (20) @(negedge clk);
        check(code2, MIDSCALE);
        // full frame after abort, shift register was cleared
        sync2(1'b0);
        bits2(24'h012468, 23, 0);
        sync2(1'b1);
        repeat (20) @(negedge clk);
        check(code2, 16'h2468);
        check(mode2, MODE_HIZ);
        // reset word survives a sync rise after its first byte
        sync2(1'b0);
        bits2(SWRESET_WORD, 23, 16);
        sync2(1'b1);
        sync2(1'b1);
        sync2(1'b0);
        bits2(SWRESET_WORD, 15, 0);
        sync2(1'b1);
        repeat (20) @(negedge clk);
        check(code2, MIDSCALE);
        check(mode2, MODE_NORMAL);
        // seven normal frames and one reset frame went to the first device
        check(upd_cnt, 32'h00000007);
        check(swr_cnt, 32'h00000001);
        wrap_up();
    end
endmodule

// file: rtl/dac_link_if.sv
// three-wire write link: host drives all three wires
interface dac_link_if;
    logic sync_n; // frame sync, active low
    logic sclk; // serial clock, data taken on falling edge
    logic din; // serial data, msb first

    modport host (
        output sync_n,
        output sclk,
        output din
    );
    modport dac (
        input sync_n,
        input sclk,
        input din
    );
endinterface

// file: rtl/dac_port_pkg.sv
package dac_port_pkg;
    // frame geometry
    localparam int FRAME_BITS = 24;
    localparam int CODE_W = 16;
    localparam int CNT_W = 5;
    localparam int MODE_HI_POS = 17; // mode_bit_upper
    localparam int MODE_LO_POS = 16; // mode_bit_lower
    localparam int THERMO_W = 15;
    localparam int LADDER_W = 12;
    localparam int THERMO_SEL_W = 4;
    // last bit index of a frame, and of the reset-lock prefix
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
    localparam logic [CNT_W-1:0] LOCK_BIT = 5'h07;
    localparam logic [7:0] LOCK_PREFIX = 8'hff;
    // codes
    localparam logic [CODE_W-1:0] MIDSCALE = 16'h8000;
    localparam logic [CODE_W-1:0] ZERO_SCALE = 16'h0000;
    localparam logic [CODE_W-1:0] FULL_SCALE = 16'hffff;
    localparam logic [FRAME_BITS-1:0] SWRESET_WORD = 24'hffffff;
    // output modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_HIZ = 2'h1;
    localparam logic [1:0] MODE_PD_100K = 2'h2;
    localparam logic [1:0] MODE_PD_1K = 2'h3;
    // timing, host clock at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_HIGH_NS = 12;
    localparam int SYNC_HIGH_CYC =
        (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_5V_NS = 2500;
    localparam int RECOVER_3V_NS = 5000;
    localparam int RECOVER_5V_CYC =
        (RECOVER_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_3V_CYC =
        (RECOVER_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_DEF = 2;
endpackage

// file: rtl/dac_serial_write_port.sv
module dac_serial_write_port
    import dac_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    dac_link_if.dac link,
    output logic [CODE_W-1:0] dac_code_r,
    output logic [1:0] mode_r,
    output logic [THERMO_W-1:0] thermo_sw_r,
    output logic [LADDER_W-1:0] ladder_sw_r,
    output logic amp_connect_r,
    output logic core_on_r,
    output logic out_hiz_r,
    output logic pull_100k_r,
    output logic pull_1k_r,
    output logic update_pulse_r,
    output logic swreset_pulse_r
);
    // ---------------- link domain, falling edge of sclk ----------------
    logic [FRAME_BITS-1:0] shift_r; // input shift register
    logic [CNT_W-1:0] bit_cnt_r; // bits taken in this frame
    logic frame_done_r; // 24 bits in, wait for sync high
    logic swr_lock_r; // reset prefix seen, abort disabled
    logic [FRAME_BITS-1:0] frame_word_r; // last complete frame
    logic frame_tgl_r; // flips once per complete frame
    logic frame_clr; // async clear of the frame state
    logic [FRAME_BITS-1:0] shift_nxt;

    // sync high clears the frame unless the reset prefix has locked it;
    // a rise between clock edges must still abort, hence the async path
    assign frame_clr = rst | (link.sync_n & ~swr_lock_r);
    assign shift_nxt = {shift_r[FRAME_BITS-2:0], link.din};

    // shift register and bit counter
    always_ff @(negedge link.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            shift_r <= '0;
            bit_cnt_r <= '0;
            frame_done_r <= 1'b0;
        end else if (!link.sync_n && !frame_done_r) begin
            shift_r <= shift_nxt;
            if (bit_cnt_r == LAST_BIT) begin
                bit_cnt_r <= '0;
                frame_done_r <= 1'b1;
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // lock against abort once the all-ones prefix has arrived
    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            swr_lock_r <= 1'b0;
        end else if (!link.sync_n && !frame_done_r) begin
            if (bit_cnt_r == LOCK_BIT &&
                shift_nxt[7:0] == LOCK_PREFIX) begin
                swr_lock_r <= 1'b1;
            end else if (bit_cnt_r == LAST_BIT) begin
                swr_lock_r <= 1'b0;
            end
        end
    end

    // hand a complete frame to the system side; the word stays put for
    // at least 24 link clocks, far longer than the crossing needs
    always_ff @(negedge link.sclk or posedge rst) begin
        if (rst) begin
            frame_word_r <= '0;
            frame_tgl_r <= 1'b0;
        end else if (!link.sync_n && !frame_done_r &&
                     bit_cnt_r == LAST_BIT) begin
            frame_word_r <= shift_nxt;
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    // ---------------- system domain ----------------
    logic tgl_meta_r; // first synchroniser stage
    logic tgl_sync_r; // second stage
    logic tgl_seen_r; // previous value, for the edge
    logic frame_evt; // one complete frame arrived
    logic [CODE_W-1:0] code_nxt;
    logic [1:0] mode_nxt;
    logic is_swreset;

    // two-flop crossing for the frame toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tgl_meta_r <= 1'b0;
            tgl_sync_r <= 1'b0;
            tgl_seen_r <= 1'b0;
        end else begin
            tgl_meta_r <= frame_tgl_r;
            tgl_sync_r <= tgl_meta_r;
            tgl_seen_r <= tgl_sync_r;
        end
    end

    // one-cycle strobe per toggle change; the frame word it qualifies
    // was written on the same edge as the toggle flipped and has long been still,
    // so it may be read here without a synchroniser of its own
    assign frame_evt = tgl_sync_r ^ tgl_seen_r;
    assign is_swreset = (frame_word_r == SWRESET_WORD);

    // decode the new code and mode; upper bits 23..18 matter only to spot the reset word
    always_comb begin
        code_nxt = dac_code_r;
        mode_nxt = mode_r;
        if (frame_evt) begin
            if (is_swreset) begin
                code_nxt = MIDSCALE;
                mode_nxt = MODE_NORMAL;
            end else begin
                code_nxt = frame_word_r[CODE_W-1:0];
                mode_nxt = {frame_word_r[MODE_HI_POS],
                            frame_word_r[MODE_LO_POS]};
            end
        end
    end

    // dac register: midscale from power-up; every frame but the reset word, mode change or not, loads its low 16 bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_code_r <= MIDSCALE;
            mode_r <= MODE_NORMAL;
        end else begin
            dac_code_r <= code_nxt;
            mode_r <= mode_nxt;
        end
    end

    // event pulses, one clock each
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            update_pulse_r <= 1'b0;
            swreset_pulse_r <= 1'b0;
        end else begin
            update_pulse_r <= frame_evt & ~is_swreset;
            swreset_pulse_r <= frame_evt & is_swreset;
        end
    end

    // output stage steering from the mode field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            amp_connect_r <= 1'b1;
            core_on_r <= 1'b1;
            out_hiz_r <= 1'b0;
            pull_100k_r <= 1'b0;
            pull_1k_r <= 1'b0;
        end else begin
            amp_connect_r <= (mode_nxt == MODE_NORMAL);
            core_on_r <= (mode_nxt == MODE_NORMAL);
            out_hiz_r <= (mode_nxt == MODE_HIZ);
            pull_100k_r <= (mode_nxt == MODE_PD_100K);
            pull_1k_r <= (mode_nxt == MODE_PD_1K);
        end
    end

    // binary ladder takes the low twelve bits straight; fed from the
    // next-state code so it moves on the same edge as the register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ladder_sw_r <= MIDSCALE[LADDER_W-1:0];
        end else begin
            ladder_sw_r <= code_nxt[LADDER_W-1:0];
        end
    end

    // thermometer: switch k closes when top nibble exceeds k
    logic [THERMO_SEL_W-1:0] top_nib;
    assign top_nib = code_nxt[CODE_W-1 -: THERMO_SEL_W];

    genvar k;
    generate
        for (k = 0; k < THERMO_W; k++) begin : g_thermo
            localparam logic [THERMO_SEL_W-1:0] IDX = THERMO_SEL_W'(k);
            localparam logic MID_ON =
                (MIDSCALE[CODE_W-1 -: THERMO_SEL_W] > IDX);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    thermo_sw_r[k] <= MID_ON;
                end else begin
                    thermo_sw_r[k] <= (top_nib > IDX);
                end
            end
        end
    endgenerate
endmodule

// file: rtl/dac_write_host.sv
// host end: drives frames onto the three-wire link
module dac_write_host
    import dac_port_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF, // clk cycles per sclk half
    parameter int RECOVER_CYC = RECOVER_3V_CYC, // settle after wake
    parameter bit PARK_LOW = 1'b1 // idle sync low between frames
)(
    input wire logic clk,
    input wire logic rst,
    dac_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [FRAME_BITS-1:0] cmd_word,
    output logic cmd_ready_r,
    output logic frame_sent_r,
    output logic out_settled_r
);
    typedef enum {S_IDLE, S_SYNC_HI, S_HIGH, S_LOW, S_END} state_e;

    state_e state_r; // frame sequencer
    logic [FRAME_BITS-1:0] word_r; // frame being sent, msb on top
    logic [CNT_W-1:0] bit_cnt_r; // falling edges issued
    logic [15:0] div_r; // half-period and gap timer
    logic sync_n_r;
    logic sclk_r;
    logic din_r;
    logic [15:0] settle_r; // recovery countdown
    logic was_pd_r; // last mode sent was a power-down

    assign link.sync_n = sync_n_r;
    assign link.sclk = sclk_r;
    assign link.din = din_r;

    // frame sequencer; sclk is divided down from clk, idle high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE;
            word_r <= '0;
            bit_cnt_r <= '0;
            div_r <= '0;
            sync_n_r <= 1'b1;
            sclk_r <= 1'b1;
            din_r <= 1'b0;
            cmd_ready_r <= 1'b1;
            frame_sent_r <= 1'b0;
        end else begin
            frame_sent_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (cmd_valid && cmd_ready_r) begin
                        word_r <= cmd_word;
                        cmd_ready_r <= 1'b0;
                        sync_n_r <= 1'b1;
                        div_r <= 16'(SYNC_HIGH_CYC - 1);
                        state_r <= S_SYNC_HI;
                    end
                end
                S_SYNC_HI: begin
                    if (div_r == 16'h0000) begin
                        sync_n_r <= 1'b0;
                        din_r <= word_r[FRAME_BITS-1];
                        div_r <= 16'(SCLK_HALF - 1);
                        state_r <= S_HIGH;
                    end else begin
                        div_r <= div_r - 16'h0001;
                    end
                end
                S_HIGH: begin
                    if (div_r == 16'h0000) begin
                        sclk_r <= 1'b0; // device samples here
                        div_r <= 16'(SCLK_HALF - 1);
                        state_r <= S_LOW;
                    end else begin
                        div_r <= div_r - 16'h0001;
                    end
                end
                S_LOW: begin
                    if (div_r == 16'h0000) begin
                        sclk_r <= 1'b1;
                        div_r <= 16'(SCLK_HALF - 1);
                        if (bit_cnt_r == LAST_BIT) begin
                            bit_cnt_r <= '0;
                            state_r <= S_END;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            word_r <= {word_r[FRAME_BITS-2:0], 1'b0};
                            din_r <= word_r[FRAME_BITS-2];
                            state_r <= S_HIGH;
                        end
                    end else begin
                        div_r <= div_r - 16'h0001;
                    end
                end
                S_END: begin
                    if (div_r == 16'h0000) begin
                        // parking low saves power; the next frame
                        // raises it again for the gap first
                        sync_n_r <= ~PARK_LOW;
                        frame_sent_r <= 1'b1;
                        cmd_ready_r <= 1'b1;
                        state_r <= S_IDLE;
                    end else begin
                        div_r <= div_r - 16'h0001;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // output is trusted only once the wake-up time has run out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_r <= '0;
            was_pd_r <= 1'b0;
            out_settled_r <= 1'b1;
        end else if (state_r == S_IDLE && cmd_valid && cmd_ready_r) begin
            was_pd_r <= (cmd_word[MODE_HI_POS:MODE_LO_POS] != MODE_NORMAL)
                        && (cmd_word != SWRESET_WORD);
            // a software reset also wakes the output, so it waits too
            if (was_pd_r &&
                (cmd_word[MODE_HI_POS:MODE_LO_POS] == MODE_NORMAL ||
                 cmd_word == SWRESET_WORD)) begin
                settle_r <= 16'(RECOVER_CYC);
                out_settled_r <= 1'b0;
            end
        end else if (settle_r != 16'h0000) begin
            settle_r <= settle_r - 16'h0001;
            out_settled_r <= (settle_r == 16'h0001);
        end
    end
endmodule
